// ---- inc/dso_pkg.sv ----
/*
  Package for the distance switch output logic: register map, field layout,
  mode and setting encodings, reset values and timing counts.
  Assumes a 10 MHz ref_clk and millimetre distances from the echo stage.
*/
// Behaviour
// - retroreflective: object nearer than reference window changes the output
// - retroreflective: beyond the window counts as missing echo, output changes
// - switch point 2 ignored in switch-point and retroreflective modes
// - polarity setting picks normally-open or normally-closed output
// - switch points are writable millimetre distances within the adjustment range
// - points given in wrong order are swapped before evaluation
// - settings of an absent output are stored but never drive it
// - retroreflective offset is 1 up to half the adjustment range end
// - offset extends equally toward and away from the sensor around point 1
// - switching hysteresis is not applied in hysteresis mode
// - hysteresis low, medium, high is 1, 2, 5 percent of distance
// - hysteresis is never less than 1 mm
// - switch-on delay 0 to 60000 ms postpones switch-on transition
// - switch-on delay acts open-to-closed for NO, closed-to-open for NC
// - switch-point mode: output changes crossing point 1, either direction
// - window mode: active only while distance between the two points
// - hysteresis mode: set reaching point 1, revert only past point 2
// - switch-off delay 0 to 60000 ms postpones the opposite transition
package dso_pkg;
  localparam int DIST_W = 16;
  localparam int DLY_W = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] REG_MODE = 4'h0;
  localparam logic [ADDR_W-1:0] REG_SP1 = 4'h1;
  localparam logic [ADDR_W-1:0] REG_SP2 = 4'h2;
  localparam logic [ADDR_W-1:0] REG_OFFSET = 4'h3;
  localparam logic [ADDR_W-1:0] REG_ON_DLY = 4'h4;
  localparam logic [ADDR_W-1:0] REG_OFF_DLY = 4'h5;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h6;
  localparam logic [ADDR_W-1:0] REG_DIST = 4'h7;

  // fields of REG_MODE
  localparam int F_MODE_LSB = 0;
  localparam int F_NC_BIT = 2;
  localparam int F_HYST_LSB = 3;
  localparam int F_PRESENT_BIT = 5;

  typedef enum logic [1:0] {
    DSO_SWITCH_POINT,
    DSO_WINDOW,
    DSO_HYSTERESIS,
    DSO_RETRO
  } dso_mode_t;

  localparam logic [1:0] HYST_LOW = 2'h0;
  localparam logic [1:0] HYST_MED = 2'h1;
  localparam logic [1:0] HYST_HIGH = 2'h2;
  localparam logic [7:0] HYST_PCT_LOW = 8'h01;
  localparam logic [7:0] HYST_PCT_MED = 8'h02;
  localparam logic [7:0] HYST_PCT_HIGH = 8'h05;
  localparam logic [DIST_W-1:0] HYST_MIN_MM = 16'h0001;

  localparam logic [DIST_W-1:0] ADJ_BEGIN_MM = 16'h001E;
  localparam logic [DIST_W-1:0] ADJ_END_MM = 16'h0FA0;
  localparam logic [DIST_W-1:0] OFFSET_MIN_MM = 16'h0001;
  localparam logic [DIST_W-1:0] OFFSET_MAX_MM = ADJ_END_MM >> 1;
  localparam logic [DLY_W-1:0] DLY_MAX_MS = 16'hEA60;

  localparam logic [DIST_W-1:0] SP1_RST = 16'h01F4;
  localparam logic [DIST_W-1:0] SP2_RST = 16'h03E8;
  localparam logic [DIST_W-1:0] OFFSET_RST = 16'h0032;
  localparam logic [5:0] MODE_RST = 6'h20;

  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_W = 14;
endpackage

// ---- core/dso_delay_timer.sv ----
/*
  Persistence timer that lets a level through only after it has held
  for a programmed number of millisecond ticks.
  Assumes ms_tick is a one-cycle pulse in the same clock domain.
*/
`timescale 1ns/1ns
module dso_delay_timer
  import dso_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ms_tick,
  input wire logic raw_in,
  input wire logic [DLY_W-1:0] on_ms,
  input wire logic [DLY_W-1:0] off_ms,
  output logic out_lvl
);
  logic out_ff;
  logic nxt_out;
  logic [DLY_W-1:0] cnt_ff;
  logic [DLY_W-1:0] nxt_cnt;
  logic [DLY_W-1:0] need;

  always_comb begin
    nxt_out = out_ff;
    nxt_cnt = cnt_ff;
    need = raw_in ? on_ms : off_ms;
    if (raw_in == out_ff) begin
      nxt_cnt = '0;
    end else if (need == '0) begin
      nxt_out = raw_in;
      nxt_cnt = '0;
    end else if (ms_tick) begin
      if (cnt_ff + 16'h0001 >= need) begin
        nxt_out = raw_in;
        nxt_cnt = '0;
      end else begin
        nxt_cnt = cnt_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_ff <= 1'b0;
      cnt_ff <= '0;
    end else begin
      out_ff <= nxt_out;
      cnt_ff <= nxt_cnt;
    end
  end

  assign out_lvl = out_ff;
endmodule

// ---- core/dso_switch_output.sv ----
/*
  Switching output evaluation: mode logic, hysteresis, polarity, delays
  and the configuration register port.
  Assumes dist_mm with dist_valid from the echo stage, synchronous to ref_clk;
  echo_lost means no echo came back this measurement.
*/
`timescale 1ns/1ns
module dso_switch_output
  import dso_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [DIST_W-1:0] dist_mm,
  input wire logic dist_valid,
  input wire logic echo_lost,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic switch_out
);
  logic [5:0] mode_reg_ff, nxt_mode_reg;
  logic [DIST_W-1:0] sp1_ff, nxt_sp1, sp2_ff, nxt_sp2, offset_ff, nxt_offset;
  logic [DLY_W-1:0] on_dly_ff, nxt_on_dly, off_dly_ff, nxt_off_dly;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [DIST_W-1:0] dist_ff, nxt_dist;
  logic lost_ff, nxt_lost;
  logic detect_ff, nxt_detect;
  logic [TICK_W-1:0] tick_cnt_ff, nxt_tick_cnt;
  logic ms_tick;
  logic delayed;

  dso_mode_t mode;
  logic nc_pol;
  logic [1:0] hyst_sel;
  logic present;
  logic [DIST_W-1:0] near_pt, far_pt, hyst_mm, win_lo, win_hi;
  logic [DIST_W+7:0] hyst_prod;
  logic [DIST_W:0] win_hi_w;
  logic [DIST_W-1:0] wdata_d;
  logic wdata_hi;
  logic [DIST_W:0] dist_up;

  assign mode = dso_mode_t'(mode_reg_ff[F_MODE_LSB +: 2]);
  assign nc_pol = mode_reg_ff[F_NC_BIT];
  assign hyst_sel = mode_reg_ff[F_HYST_LSB +: 2];
  assign present = mode_reg_ff[F_PRESENT_BIT];
  assign wdata_d = reg_wdata[DIST_W-1:0];
  // any upper bit set means the value is above every limit; never let it wrap
  assign wdata_hi = |reg_wdata[DATA_W-1:DIST_W];

  // register port
  always_comb begin
    nxt_mode_reg = mode_reg_ff;
    nxt_sp1 = sp1_ff;
    nxt_sp2 = sp2_ff;
    nxt_offset = offset_ff;
    nxt_on_dly = on_dly_ff;
    nxt_off_dly = off_dly_ff;
    nxt_rdata = '0;
    if (reg_wr) begin
      case (reg_addr)
        REG_MODE: nxt_mode_reg = reg_wdata[5:0];
        REG_SP1: begin
          // clamp to adjustment range
          if (wdata_hi || wdata_d > ADJ_END_MM) nxt_sp1 = ADJ_END_MM;
          else if (wdata_d < ADJ_BEGIN_MM) nxt_sp1 = ADJ_BEGIN_MM;
          else nxt_sp1 = wdata_d;
        end
        REG_SP2: begin
          if (wdata_hi || wdata_d > ADJ_END_MM) nxt_sp2 = ADJ_END_MM;
          else if (wdata_d < ADJ_BEGIN_MM) nxt_sp2 = ADJ_BEGIN_MM;
          else nxt_sp2 = wdata_d;
        end
        REG_OFFSET: begin
          if (wdata_hi || wdata_d > OFFSET_MAX_MM) nxt_offset = OFFSET_MAX_MM;
          else if (wdata_d < OFFSET_MIN_MM) nxt_offset = OFFSET_MIN_MM;
          else nxt_offset = wdata_d;
        end
        REG_ON_DLY: begin
          nxt_on_dly = (wdata_hi || reg_wdata[DLY_W-1:0] > DLY_MAX_MS) ? DLY_MAX_MS
                       : reg_wdata[DLY_W-1:0];
        end
        REG_OFF_DLY: begin
          nxt_off_dly = (wdata_hi || reg_wdata[DLY_W-1:0] > DLY_MAX_MS) ? DLY_MAX_MS
                        : reg_wdata[DLY_W-1:0];
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_MODE: nxt_rdata = {26'h0, mode_reg_ff};
        REG_SP1: nxt_rdata = {16'h0, sp1_ff};
        REG_SP2: nxt_rdata = {16'h0, sp2_ff};
        REG_OFFSET: nxt_rdata = {16'h0, offset_ff};
        REG_ON_DLY: nxt_rdata = {16'h0, on_dly_ff};
        REG_OFF_DLY: nxt_rdata = {16'h0, off_dly_ff};
        REG_STATUS: nxt_rdata = {29'h0, switch_out, delayed, detect_ff};
        REG_DIST: nxt_rdata = {15'h0, lost_ff, dist_ff};
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_reg_ff <= MODE_RST;
      sp1_ff <= SP1_RST;
      sp2_ff <= SP2_RST;
      offset_ff <= OFFSET_RST;
      on_dly_ff <= '0;
      off_dly_ff <= '0;
      rdata_ff <= '0;
    end else begin
      mode_reg_ff <= nxt_mode_reg;
      sp1_ff <= nxt_sp1;
      sp2_ff <= nxt_sp2;
      offset_ff <= nxt_offset;
      on_dly_ff <= nxt_on_dly;
      off_dly_ff <= nxt_off_dly;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // millisecond tick
  always_comb begin
    ms_tick = (tick_cnt_ff == TICK_W'(TICK_CYC - 1));
    nxt_tick_cnt = ms_tick ? '0 : tick_cnt_ff + 14'h0001;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) tick_cnt_ff <= '0;
    else tick_cnt_ff <= nxt_tick_cnt;
  end

  // evaluation geometry
  always_comb begin
    // points swapped so near_pt is always the nearer one
    if (sp1_ff > sp2_ff) begin
      near_pt = sp2_ff;
      far_pt = sp1_ff;
    end else begin
      near_pt = sp1_ff;
      far_pt = sp2_ff;
    end
    case (hyst_sel)
      HYST_LOW: hyst_prod = dist_ff * HYST_PCT_LOW;
      HYST_MED: hyst_prod = dist_ff * HYST_PCT_MED;
      HYST_HIGH: hyst_prod = dist_ff * HYST_PCT_HIGH;
      default: hyst_prod = dist_ff * HYST_PCT_LOW;
    endcase
    hyst_mm = DIST_W'(hyst_prod / 24'd100);
    if (hyst_mm < HYST_MIN_MM) hyst_mm = HYST_MIN_MM;
    // one extra bit so a distance near full scale cannot wrap to a near one
    dist_up = {1'b0, dist_ff} + {1'b0, hyst_mm};
    // symmetric reference window around point 1
    win_lo = (sp1_ff > offset_ff) ? sp1_ff - offset_ff : '0;
    win_hi_w = {1'b0, sp1_ff} + {1'b0, offset_ff};
    win_hi = win_hi_w[DIST_W] ? '1 : win_hi_w[DIST_W-1:0];
  end

  // detection per mode; hysteresis keeps the previous decision inside the band
  always_comb begin
    nxt_dist = dist_ff;
    nxt_lost = lost_ff;
    nxt_detect = detect_ff;
    if (dist_valid) begin
      nxt_dist = dist_mm;
      nxt_lost = echo_lost;
    end
    case (mode)
      DSO_SWITCH_POINT: begin
        // only point 1 used here
        if (lost_ff) nxt_detect = 1'b0;
        else if (dist_up <= {1'b0, sp1_ff}) nxt_detect = 1'b1;
        else if (dist_ff >= sp1_ff + hyst_mm) nxt_detect = 1'b0;
      end
      DSO_WINDOW: begin
        if (lost_ff) nxt_detect = 1'b0;
        else if (dist_up <= {1'b0, near_pt} || dist_ff >= far_pt + hyst_mm)
          nxt_detect = 1'b0;
        else if (dist_ff >= near_pt && dist_ff <= far_pt) nxt_detect = 1'b1;
      end
      DSO_HYSTERESIS: begin
        // the two points are the band; the hysteresis setting is not used
        if (lost_ff) nxt_detect = 1'b0;
        else if (dist_ff <= near_pt) nxt_detect = 1'b1;
        else if (dist_ff > far_pt) nxt_detect = 1'b0;
      end
      DSO_RETRO: begin
        // missing echo and too far are handled like a blocked reflector
        if (lost_ff) nxt_detect = 1'b1;
        else if (dist_ff < win_lo) nxt_detect = 1'b1;
        else if (dist_ff > win_hi) nxt_detect = 1'b1;
        else nxt_detect = 1'b0;
      end
      default: nxt_detect = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dist_ff <= '0;
      lost_ff <= 1'b1;
      detect_ff <= 1'b0;
    end else begin
      dist_ff <= nxt_dist;
      lost_ff <= nxt_lost;
      detect_ff <= nxt_detect;
    end
  end

  // timer runs on detection; polarity sits after it so on/off follow detection, not output level
  dso_delay_timer u_delay (
    .ref_clk(ref_clk),
    .rst(rst),
    .ms_tick(ms_tick),
    .raw_in(detect_ff),
    .on_ms(on_dly_ff),
    .off_ms(off_dly_ff),
    .out_lvl(delayed)
  );

  // polarity maps the delayed detection; absent output stays inactive (open)
  assign switch_out = present & (delayed ^ nc_pol);
endmodule

// ---- bench/dso_switch_output_monitor.sv ----
/* checker for dso_switch_output: register answers and output gating
   sees only the top ports; bound to every instance below */
`timescale 1ns/1ns
module dso_switch_output_monitor
  import dso_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [DIST_W-1:0] dist_mm,
  input wire logic dist_valid,
  input wire logic echo_lost,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic switch_out
);
  logic [5:0] mode_wr;
  assign mode_wr = reg_wdata[5:0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == '0) else $error("read data not idle");
  a_point_range: assert property (
    reg_rd && (reg_addr == REG_SP1 || reg_addr == REG_SP2)
    |=> reg_rdata inside {[ADJ_BEGIN_MM:ADJ_END_MM]}) else $error("point out of range");
  a_offset_range: assert property (
    reg_rd && reg_addr == REG_OFFSET
    |=> reg_rdata inside {[OFFSET_MIN_MM:OFFSET_MAX_MM]}) else $error("offset out of range");
  a_delay_range: assert property (
    reg_rd && (reg_addr == REG_ON_DLY || reg_addr == REG_OFF_DLY)
    |=> reg_rdata <= DLY_MAX_MS) else $error("delay out of range");
  a_absent_quiet: assert property (
    reg_rd && reg_addr == REG_MODE ##1 !reg_rdata[F_PRESENT_BIT]
    |-> !switch_out) else $error("absent output driven");
  a_status_match: assert property (
    reg_rd && reg_addr == REG_STATUS
    |=> reg_rdata[2] == $past(switch_out) && reg_rdata[31:3] == '0) else $error("status bad");
  a_dist_capture: assert property (
    dist_valid ##1 (reg_rd && reg_addr == REG_DIST)
    |=> reg_rdata == {15'h0, $past(echo_lost, 2), $past(dist_mm, 2)}) else $error("dist bad");
  a_mode_readback: assert property (
    reg_wr && reg_addr == REG_MODE ##1 reg_rd && reg_addr == REG_MODE
    |=> reg_rdata == {26'h0, $past(mode_wr, 2)}) else $error("mode readback bad");
endmodule
bind dso_switch_output dso_switch_output_monitor dso_switch_output_monitor_i (
  .ref_clk(ref_clk), .rst(rst), .dist_mm(dist_mm), .dist_valid(dist_valid),
  .echo_lost(echo_lost), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .switch_out(switch_out));

// ---- bench/dso_plc_model.sv ----
/* controller input model that scans the switching output
   assumes it shares ref_clk with the sensor logic */
`timescale 1ns/1ns
module dso_plc_model (
  input wire logic ref_clk,
  input wire logic switch_in,
  output logic seen
);
  // scan every cycle so that no short pulse slips between scans
  always_ff @(posedge ref_clk) begin
    seen <= switch_in;
  end
endmodule

// ---- bench/tb_top.sv ----
/* self-checking bench for dso_switch_output: bus tasks, mode cases, delays
   assumes the package register map and a 10000-cycle millisecond tick */
`timescale 1ns/1ns
module tb_top;
  import dso_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [DIST_W-1:0] dist_mm = '0;
  logic dist_valid = 1'b0;
  logic echo_lost = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic switch_out;
  logic plc_seen;
  int err_count = 0;
  int samples_checked = 0;
  always #50 ref_clk = ~ref_clk;
  dso_switch_output dso_switch_output_i (.ref_clk(ref_clk), .rst(rst), .dist_mm(dist_mm),
    .dist_valid(dist_valid), .echo_lost(echo_lost), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .switch_out(switch_out));
  dso_plc_model dso_plc_model_i (.ref_clk(ref_clk), .switch_in(switch_out), .seen(plc_seen));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // the write strobe stays up so writes run back to back; the next task drops it
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    check(reg_rdata, e);
    @(posedge ref_clk);
  endtask
  task automatic meas(input logic [DIST_W-1:0] d, input logic l, input logic e);
    reg_wr <= 1'b0;
    dist_mm <= d;
    echo_lost <= l;
    dist_valid <= 1'b1;
    @(posedge ref_clk);
    dist_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    check({31'h0, switch_out}, {31'h0, e});
    @(posedge ref_clk);
  endtask
  // two ticks must pass, so the change cannot come sooner than one tick period
  task automatic wait_out(input logic e);
    int n;
    n = 0;
    while (plc_seen !== e && n < 25000) begin
      @(negedge ref_clk);
      n++;
    end
    check({31'h0, n >= 9990 && n < 25000}, 32'h1);
    @(posedge ref_clk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge ref_clk);
    err_count++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(REG_MODE, 32'h20);
    rd(REG_SP1, 32'h1F4);
    rd(REG_OFFSET, 32'h32);
    rd(REG_DIST, 32'h10000);
    rd(4'hF, 32'h0);
    dist_mm <= 16'h0123;
    echo_lost <= 1'b0;
    dist_valid <= 1'b1;
    @(posedge ref_clk);
    dist_valid <= 1'b0;
    rd(REG_DIST, 32'h123);
    $display("test reset done");
    wr(REG_SP2, 32'h12C);
    meas(16'h190, 1'b0, 1'b1);
    meas(16'h258, 1'b0, 1'b0);
    wr(REG_MODE, 32'h24);
    meas(16'h190, 1'b0, 1'b0);
    meas(16'h258, 1'b0, 1'b1);
    wr(REG_MODE, 32'h28);
    meas(16'h1EF, 1'b0, 1'b0);
    $display("test point done");
    wr(REG_SP2, 32'h3E8);
    wr(REG_MODE, 32'h31);
    rd(REG_MODE, 32'h31);
    meas(16'h2BC, 1'b0, 1'b1);
    meas(16'h4B0, 1'b0, 1'b0);
    meas(16'h12C, 1'b0, 1'b0);
    wr(REG_SP1, 32'h3E8);
    wr(REG_SP2, 32'h1F4);
    meas(16'h2BC, 1'b0, 1'b1);
    meas(16'h4B0, 1'b0, 1'b0);
    $display("test window done");
    wr(REG_MODE, 32'h32);
    meas(16'h190, 1'b0, 1'b1);
    meas(16'h2BC, 1'b0, 1'b1);
    meas(16'h3F2, 1'b0, 1'b0);
    meas(16'h4B0, 1'b0, 1'b0);
    meas(16'h2BC, 1'b0, 1'b0);
    $display("test hysteresis done");
    wr(REG_MODE, 32'h23);
    wr(REG_OFFSET, 32'h64);
    wr(REG_SP2, 32'h12C);
    meas(16'h41A, 1'b0, 1'b0);
    meas(16'h352, 1'b0, 1'b1);
    meas(16'h47E, 1'b0, 1'b1);
    meas(16'h3B6, 1'b0, 1'b0);
    meas(16'h41A, 1'b1, 1'b1);
    rd(REG_DIST, 32'h1041A);
    wr(REG_MODE, 32'h03);
    meas(16'h352, 1'b0, 1'b0);
    rd(REG_MODE, 32'h03);
    rd(REG_STATUS, 32'h3);
    $display("test retro done");
    wr(REG_SP1, 32'hA);
    rd(REG_SP1, 32'h1E);
    wr(REG_MODE, 32'h20);
    meas(16'h1F, 1'b0, 1'b0);
    meas(16'h1E, 1'b0, 1'b0);
    meas(16'h1D, 1'b0, 1'b1);
    wr(REG_OFFSET, 32'hBB8);
    rd(REG_OFFSET, 32'h7D0);
    wr(REG_OFFSET, 32'h0);
    rd(REG_OFFSET, 32'h1);
    wr(REG_ON_DLY, 32'h11170);
    rd(REG_ON_DLY, 32'hEA60);
    $display("test limits done");
    wr(REG_MODE, 32'h20);
    wr(REG_SP1, 32'h1F4);
    wr(REG_ON_DLY, 32'h2);
    meas(16'h258, 1'b0, 1'b0);
    meas(16'h190, 1'b0, 1'b0);
    repeat (9000) @(posedge ref_clk);
    meas(16'h258, 1'b0, 1'b0);
    meas(16'h190, 1'b0, 1'b0);
    wait_out(1'b1);
    wr(REG_ON_DLY, 32'h0);
    wr(REG_OFF_DLY, 32'h2);
    meas(16'h258, 1'b0, 1'b1);
    wait_out(1'b0);
    wr(REG_MODE, 32'h24);
    wr(REG_OFF_DLY, 32'h0);
    wr(REG_ON_DLY, 32'h2);
    meas(16'h258, 1'b0, 1'b1);
    meas(16'h190, 1'b0, 1'b1);
    wait_out(1'b0);
    $display("test delays done");
    close_out();
  end
endmodule
